// File: oref_ctrl.sv
// control-pin logic: enable, mode select, pwm gating, serial level receiver
`timescale 1ns/10ps
`default_nettype none
module oref_ctrl
  import oref_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYC  = SHUTDOWN_CYC_DEF,
  parameter int unsigned DET_LOW_CYC   = DET_LOW_CYC_DEF,
  parameter int unsigned DET_WIN_CYC   = DET_WIN_CYC_DEF,
  parameter int unsigned ACK_PULSE_CYC = ACK_PULSE_CYC_DEF
)
(
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            ctrl_i,
  output logic                 ctrl_o,
  output logic                 ctrl_oe_n_o,
  input  wire logic            supply_low_lockout_i,
  input  wire logic            over_temp_i,
  input  wire logic            level_hold_i,
  output logic                 switch_enable_o,
  output logic                 serial_mode_o,
  output logic                 ref_gate_o,
  output logic [LEVEL_W-1:0]   level_code_o,
  output logic [MV_W-1:0]      ref_level_mv_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic               ctrl_s1;
    logic               ctrl_s2;
    logic               ctrl_d;
    logic               lock_s1;
    logic               lock_s2;
    logic               hot_s1;
    logic               hot_s2;
    oref_mode_t         mode;
    logic [CNT_W-1:0]   win_cnt;
    logic [CNT_W-1:0]   low_cnt;
    logic [CNT_W-1:0]   high_cnt;
    logic [CNT_W-1:0]   low_len;
    logic               det_ok;
    logic               bit_open;
    logic [4:0]         bit_idx;
    logic [CMD_W-1:0]   shreg;
    logic               bit_err;
    logic               ack_wait;
    logic               ack_on;
    logic [CNT_W-1:0]   ack_cnt;
    logic [LEVEL_W-1:0] level;
    logic [MV_W-1:0]    ref_mv;
    logic               gate;
    logic               en;
  } oref_state_t;

  oref_state_t st_ff;
  oref_state_t nxt_st;

  oref_cmd_if cmd_in ();
  oref_cmd_if cmd_out ();

  logic               pin;
  logic               rise;
  logic               fall;
  logic               fault;
  logic               bit_one;
  logic               bit_zero;
  logic [CMD_W-1:0]   cmd;
  logic               cmd_ok;
  logic               push_valid;
  logic [LEVEL_W-1:0] push_data;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st     = st_ff;
    push_valid = 1'b0;
    push_data  = '0;
    cmd        = '0;
    cmd_ok     = 1'b0;
    bit_one    = 1'b0;
    bit_zero   = 1'b0;

    // pin and fault indications pass two flops first
    nxt_st.ctrl_s1 = ctrl_i;
    nxt_st.ctrl_s2 = st_ff.ctrl_s1;
    nxt_st.ctrl_d  = st_ff.ctrl_s2;
    nxt_st.lock_s1 = supply_low_lockout_i;
    nxt_st.lock_s2 = st_ff.lock_s1;
    nxt_st.hot_s1  = over_temp_i;
    nxt_st.hot_s2  = st_ff.hot_s1;

    pin   = st_ff.ctrl_s2;
    rise  = pin && !st_ff.ctrl_d;
    fall  = !pin && st_ff.ctrl_d;
    fault = st_ff.lock_s2 || st_ff.hot_s2;

    // phase length counters
    nxt_st.low_cnt  = pin ? '0 : sat_inc(st_ff.low_cnt);
    nxt_st.high_cnt = pin ? sat_inc(st_ff.high_cnt) : '0;
    if (rise)
    begin
      nxt_st.low_len = st_ff.low_cnt;
    end
    nxt_st.win_cnt = sat_inc(st_ff.win_cnt);

    case (st_ff.mode)
      OREF_OFF:
      begin
        // a high pin after shutdown enables; thermal restart also lands here
        if (pin && !fault)
        begin
          nxt_st.mode    = OREF_DETECT;
          nxt_st.win_cnt = '0;
          nxt_st.det_ok  = 1'b0;
        end
      end
      OREF_DETECT:
      begin
        if (fall)
        begin
          nxt_st.det_ok = (st_ff.win_cnt >= CNT_W'(DET_DELAY_CYC));
        end
        if (!pin && st_ff.det_ok && st_ff.low_cnt >= CNT_W'(DET_LOW_CYC)
            && st_ff.win_cnt < CNT_W'(DET_WIN_CYC))
        begin
          nxt_st.mode     = OREF_SERIAL;
          nxt_st.bit_open = 1'b0;
          nxt_st.bit_idx  = '0;
          nxt_st.bit_err  = 1'b0;
          nxt_st.ack_wait = 1'b0;
          nxt_st.ack_on   = 1'b0;
        end
        else if (st_ff.win_cnt >= CNT_W'(DET_WIN_CYC))
        begin
          nxt_st.mode = OREF_PWM;
        end
      end
      OREF_PWM:
      begin
        nxt_st.mode = OREF_PWM;
      end
      OREF_SERIAL:
      begin
        if (st_ff.ack_on)
        begin
          nxt_st.ack_cnt = sat_inc(st_ff.ack_cnt);
          if (st_ff.ack_cnt >= CNT_W'(ACK_PULSE_CYC - 1))
          begin
            nxt_st.ack_on = 1'b0;
          end
        end
        else if (st_ff.ack_wait)
        begin
          nxt_st.ack_cnt = sat_inc(st_ff.ack_cnt);
          if (st_ff.ack_cnt >= CNT_W'(ACK_DELAY_CYC - 1))
          begin
            nxt_st.ack_wait = 1'b0;
            nxt_st.ack_on   = 1'b1;
            nxt_st.ack_cnt  = '0;
          end
        end
        else if (fall && !st_ff.bit_open)
        begin
          nxt_st.bit_open = 1'b1;
        end
        else if (fall)
        begin
          // ratio decides, whatever the bit rate
          bit_one  = {1'b0, st_ff.high_cnt} >= {st_ff.low_len, 1'b0};
          bit_zero = {1'b0, st_ff.low_len} >= {st_ff.high_cnt, 1'b0};
          cmd      = {st_ff.shreg[CMD_W-2:0], bit_one};
          nxt_st.shreg   = cmd;
          nxt_st.bit_err = st_ff.bit_err || !(bit_one || bit_zero);
          nxt_st.bit_idx = st_ff.bit_idx + 5'h01;
          if (st_ff.bit_idx == ADDR_LAST)
          begin
            nxt_st.bit_open = 1'b0;
          end
          if (st_ff.bit_idx == LAST_BIT)
          begin
            nxt_st.bit_open = 1'b0;
            nxt_st.bit_idx  = '0;
            nxt_st.bit_err  = 1'b0;
            // the error flag must include the bit just closed, before it is cleared
            cmd_ok = !(st_ff.bit_err || !(bit_one || bit_zero))
                     && cmd[CMD_W-1:8] == DEV_ADDR
                     && !cmd[SUB_HI_POS] && !cmd[SUB_LO_POS];
            push_valid = cmd_ok;
            push_data  = cmd[LEVEL_W-1:0];
            // a full buffer refuses the command, so it is not acknowledged
            if (cmd_ok && cmd_in.ready && cmd[ACK_REQ_POS])
            begin
              nxt_st.ack_wait = 1'b1;
              nxt_st.ack_cnt  = '0;
            end
          end
        end
      end
      default:
      begin
        nxt_st.mode = OREF_OFF;
      end
    endcase

    // shutdown from any enabled mode
    if (st_ff.mode != OREF_OFF
        && (fault || (!pin && st_ff.low_cnt >= CNT_W'(SHUTDOWN_CYC))))
    begin
      nxt_st.mode     = OREF_OFF;
      nxt_st.ack_wait = 1'b0;
      nxt_st.ack_on   = 1'b0;
    end

    // buffered level codes drain into the level register
    if (cmd_out.valid && cmd_out.ready)
    begin
      nxt_st.level = cmd_out.data;
    end

    nxt_st.en = (nxt_st.mode != OREF_OFF);
    case (nxt_st.mode)
      OREF_DETECT, OREF_PWM:
      begin
        nxt_st.gate   = pin;
        nxt_st.ref_mv = LEVEL_MV_TAB[LEVEL_RST];
      end
      OREF_SERIAL:
      begin
        nxt_st.gate   = 1'b1;
        nxt_st.ref_mv = LEVEL_MV_TAB[nxt_st.level];
      end
      default:
      begin
        nxt_st.gate   = 1'b0;
        nxt_st.ref_mv = LEVEL_MV_TAB[nxt_st.level];
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      st_ff        <= '0;
      st_ff.level  <= LEVEL_RST;
      st_ff.ref_mv <= LEVEL_MV_TAB[LEVEL_RST];
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // command buffer
  // ---------------------------------------------------------------
  assign cmd_in.valid  = push_valid;
  assign cmd_in.data   = push_data;
  assign cmd_out.ready = !level_hold_i;

  oref_buf u_buf (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .in_s    (cmd_in),
    .out_s   (cmd_out)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ctrl_o          = 1'b0;
  assign ctrl_oe_n_o     = !st_ff.ack_on;
  assign switch_enable_o = st_ff.en;
  assign serial_mode_o   = (st_ff.mode == OREF_SERIAL);
  assign ref_gate_o      = st_ff.gate;
  assign level_code_o    = st_ff.level;
  assign ref_level_mv_o  = st_ff.ref_mv;

endmodule // oref_ctrl
`default_nettype wire

// File: oref_pkg.sv
// constants and types shared by the reference control block
`default_nettype none
package oref_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

  // ---------------------------------------------------------------
  // pin timing, in ns as specified
  // ---------------------------------------------------------------
  localparam int unsigned SHUTDOWN_NS    = 2_500_000;
  localparam int unsigned DET_DELAY_NS   = 100_000;
  localparam int unsigned DET_LOW_NS     = 260_000;
  localparam int unsigned DET_WIN_NS     = 1_000_000;
  localparam int unsigned ACK_PULSE_NS   = 512_000;
  localparam int unsigned ACK_DELAY_NS   = 2_000;

  // least times round up, longest times round down
  localparam int unsigned SHUTDOWN_CYC_DEF  = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DET_DELAY_CYC     = (DET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DET_LOW_CYC_DEF   = (DET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DET_WIN_CYC_DEF   = DET_WIN_NS / CLK_PERIOD_NS;
  localparam int unsigned ACK_PULSE_CYC_DEF = ACK_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned ACK_DELAY_CYC     = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // widths, command layout, reset values
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W       = 20;
  localparam int unsigned LEVEL_W     = 5;
  localparam int unsigned MV_W        = 11;
  localparam int unsigned CMD_W       = 16;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam logic [7:0]  DEV_ADDR    = 8'h72;
  localparam logic [4:0]  LAST_BIT    = 5'h0F;
  localparam logic [4:0]  ADDR_LAST   = 5'h07;
  localparam int unsigned ACK_REQ_POS = 7;
  localparam int unsigned SUB_HI_POS  = 6;
  localparam int unsigned SUB_LO_POS  = 5;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 5'h1F;

  // reference level in mV for each level code
  localparam logic [MV_W-1:0] LEVEL_MV_TAB [32] = '{
    11'h000, 11'h01F, 11'h031, 11'h044, 11'h056, 11'h068, 11'h07B, 11'h08D,
    11'h0A0, 11'h0B2, 11'h0C5, 11'h0D7, 11'h0EA, 11'h10E, 11'h133, 11'h158,
    11'h17D, 11'h1A2, 11'h1C7, 11'h1EC, 11'h210, 11'h235, 11'h25A, 11'h27F,
    11'h2C9, 11'h313, 11'h35C, 11'h3A6, 11'h3F0, 11'h43A, 11'h483, 11'h4CD
  };

  typedef enum logic [1:0] {
    OREF_OFF,
    OREF_DETECT,
    OREF_PWM,
    OREF_SERIAL
  } oref_mode_t;

endpackage
`default_nettype wire

// File: oref_cmd_if.sv
// valid/ready carrier for received level codes
`timescale 1ns/10ps
`default_nettype none
interface oref_cmd_if;
  import oref_pkg::*;
  logic               valid;
  logic               ready;
  logic [LEVEL_W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // oref_cmd_if
`default_nettype wire

// File: oref_buf.sv
// two-entry buffer for received level codes
`timescale 1ns/10ps
`default_nettype none
module oref_buf
  import oref_pkg::*;
(
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  oref_cmd_if.snk    in_s,
  oref_cmd_if.src    out_s
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BUF_DEPTH-1:0][LEVEL_W-1:0] mem;
    logic                              wp;
    logic                              rp;
    logic [1:0]                        cnt;
  } oref_buf_t;

  oref_buf_t buf_ff;
  oref_buf_t nxt_buf;
  logic      push;
  logic      pop;

  assign in_s.ready  = (buf_ff.cnt != 2'h2);
  assign out_s.valid = (buf_ff.cnt != 2'h0);
  assign out_s.data  = buf_ff.mem[buf_ff.rp];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_buf = buf_ff;
    push    = in_s.valid && in_s.ready;
    pop     = out_s.valid && out_s.ready;
    if (push)
    begin
      nxt_buf.mem[buf_ff.wp] = in_s.data;
      nxt_buf.wp             = ~buf_ff.wp;
    end
    if (pop)
    begin
      nxt_buf.rp = ~buf_ff.rp;
    end
    if (push && !pop)
    begin
      nxt_buf.cnt = buf_ff.cnt + 2'h1;
    end
    else if (pop && !push)
    begin
      nxt_buf.cnt = buf_ff.cnt - 2'h1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      buf_ff <= '0;
    end
    else
    begin
      buf_ff <= nxt_buf;
    end
  end

endmodule // oref_buf
`default_nettype wire

// File: oref_ctrl_properties.sv
// port assertions for the control pin block
`timescale 1ns/10ps
`default_nettype none
module oref_ctrl_props
  import oref_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYC  = SHUTDOWN_CYC_DEF,
  parameter int unsigned DET_LOW_CYC   = DET_LOW_CYC_DEF,
  parameter int unsigned DET_WIN_CYC   = DET_WIN_CYC_DEF,
  parameter int unsigned ACK_PULSE_CYC = ACK_PULSE_CYC_DEF
)
(
  input wire logic               clock_i,
  input wire logic               rst_n_i,
  input wire logic               ctrl_i,
  input wire logic               ctrl_o,
  input wire logic               ctrl_oe_n_o,
  input wire logic               supply_low_lockout_i,
  input wire logic               over_temp_i,
  input wire logic               level_hold_i,
  input wire logic               switch_enable_o,
  input wire logic               serial_mode_o,
  input wire logic               ref_gate_o,
  input wire logic [LEVEL_W-1:0] level_code_o,
  input wire logic [MV_W-1:0]    ref_level_mv_o
);
  // ----
  // run lengths of a low pin and of the pull-down
  // ----
  logic [CNT_W-1:0] low_cnt_ff;
  logic [CNT_W-1:0] ack_cnt_ff;
  logic             clean;
  assign clean = !over_temp_i && !supply_low_lockout_i;
  always_ff @(posedge clock_i)
  begin
    low_cnt_ff <= (!rst_n_i || ctrl_i) ? '0 : low_cnt_ff + 1'b1;
    ack_cnt_ff <= (!rst_n_i || ctrl_oe_n_o) ? '0 : ack_cnt_ff + 1'b1;
  end
  // ----
  // properties
  // ----
  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  lockout_off_a: assert property (supply_low_lockout_i [*4] |=> !switch_enable_o)
    else $error("switch on under supply lockout");
  heat_off_a: assert property (over_temp_i [*4] |=> !switch_enable_o && !serial_mode_o)
    else $error("device on while hot");
  long_low_off_a: assert property (low_cnt_ff > SHUTDOWN_CYC + 6 |-> !switch_enable_o)
    else $error("no shutdown after long low");
  early_off_a: assert property ($fell(switch_enable_o) && clean |-> low_cnt_ff >= SHUTDOWN_CYC)
    else $error("shutdown after short low");
  ack_width_a: assert property ($rose(ctrl_oe_n_o) |-> ack_cnt_ff == ACK_PULSE_CYC)
    else $error("pull-down pulse width wrong");
  ack_delay_a: assert property ($fell(ctrl_oe_n_o) |-> low_cnt_ff >= ACK_DELAY_CYC)
    else $error("pull-down came too early");
  ack_in_serial_a: assert property (!ctrl_oe_n_o |-> serial_mode_o)
    else $error("pull-down outside serial mode");
  gate_high_a: assert property ((ctrl_i && switch_enable_o && !serial_mode_o && clean) [*6]
    |-> ref_gate_o) else $error("gate low while pin high");
  gate_low_a: assert property ((!ctrl_i && switch_enable_o && !serial_mode_o && clean) [*6]
    |-> !ref_gate_o) else $error("gate high while pin low");
  level_mv_a: assert property ((serial_mode_o && $stable(level_code_o)) [*2]
    |-> ref_level_mv_o == LEVEL_MV_TAB[level_code_o]) else $error("level table mismatch");
  pwm_full_a: assert property ((switch_enable_o && !serial_mode_o) [*2]
    |-> ref_level_mv_o == 11'h4CD) else $error("pwm reference not full scale");
  level_hold_a: assert property (level_hold_i |=> $stable(level_code_o))
    else $error("level changed while held");
  open_drain_a: assert property (!ctrl_o)
    else $error("pin driven high");
  cover property ($rose(serial_mode_o));
  cover property ($rose(ctrl_oe_n_o));
  cover property ($fell(switch_enable_o));
  cover property ($changed(level_code_o));
endmodule // oref_ctrl_props

bind oref_ctrl oref_ctrl_props #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .DET_LOW_CYC(DET_LOW_CYC),
  .DET_WIN_CYC(DET_WIN_CYC), .ACK_PULSE_CYC(ACK_PULSE_CYC)) props_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_i), .ctrl_o(ctrl_o),
  .ctrl_oe_n_o(ctrl_oe_n_o), .supply_low_lockout_i(supply_low_lockout_i),
  .over_temp_i(over_temp_i), .level_hold_i(level_hold_i),
  .switch_enable_o(switch_enable_o), .serial_mode_o(serial_mode_o),
  .ref_gate_o(ref_gate_o), .level_code_o(level_code_o), .ref_level_mv_o(ref_level_mv_o));
`default_nettype wire

// File: oref_host_model.sv
// host model driving the open-drain control pin
`timescale 1ns/10ps
`default_nettype none
module oref_host_model
  import oref_pkg::*;
(
  input  wire logic clock_i,
  output logic      pin_o
);
  // 280 clocks a bit, about 143 kbit/s
  localparam int BIT_T = 70;
  initial pin_o = 1'b0;
  // one released (pulled-up) or low level for n falling edges
  task automatic hold(input logic lv, input int n);
    pin_o = lv;
    repeat (n) @(negedge clock_i);
  endtask
  // start, bits msb first by ratio, closing fall, end gap kept low
  // a bit marked in m gets equal low and high times, which no ratio decides
  task automatic send_byte(input logic [7:0] b, input logic [7:0] m = 8'h00);
    hold(1'b1, 80);
    for (int i = 7; i >= 0; i--)
    begin
      hold(1'b0, m[i] ? 2 * BIT_T : (b[i] ? BIT_T : 3 * BIT_T));
      hold(1'b1, m[i] ? 2 * BIT_T : (b[i] ? 3 * BIT_T : BIT_T));
    end
    hold(1'b0, 100);
  endtask
  // address byte then data byte, then the line is released
  task automatic send_cmd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m = 8'h00);
    send_byte(a);
    send_byte(d, m);
    pin_o = 1'b1;
  endtask
endmodule // oref_host_model
`default_nettype wire

// File: test_oref_ctrl.sv
// self-checking bench for the control pin block
`timescale 1ns/10ps
`default_nettype none
module test_oref_ctrl;
  import oref_pkg::*;
  localparam int unsigned SD_C  = 400;
  localparam int unsigned LOW_C = 200;
  localparam int unsigned WIN_C = 5000;
  localparam int unsigned ACK_C = 50;
  logic               clock_i  = 1'b0;
  logic               rst_n_i  = 1'b0;
  logic               lockout  = 1'b0;
  logic               hot      = 1'b0;
  logic               hold_lvl = 1'b0;
  logic               host_pin;
  logic               pin;
  logic               drv;
  logic               oe_n;
  logic               sw_en;
  logic               ser;
  logic               gate;
  logic [LEVEL_W-1:0] code;
  logic [MV_W-1:0]    mv;
  int                 failures    = 0;
  int                 check_count = 0;
  int                 acks        = 0;
  int                 cycles      = 0;
  // wired-and of host and device pull-down
  assign pin = host_pin & (oe_n | drv);
  always #12.5 clock_i = ~clock_i;
  oref_ctrl #(.SHUTDOWN_CYC(SD_C), .DET_LOW_CYC(LOW_C), .DET_WIN_CYC(WIN_C),
    .ACK_PULSE_CYC(ACK_C)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ctrl_i(pin), .ctrl_o(drv),
    .ctrl_oe_n_o(oe_n), .supply_low_lockout_i(lockout), .over_temp_i(hot),
    .level_hold_i(hold_lvl), .switch_enable_o(sw_en), .serial_mode_o(ser),
    .ref_gate_o(gate), .level_code_o(code), .ref_level_mv_o(mv));
  oref_host_model host (.clock_i(clock_i), .pin_o(host_pin));
  // ----
  // shared tasks
  // ----
  task automatic results();
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] c, input logic [4:0] ec, input logic [10:0] em,
                     input int ea, input logic [7:0] am = 8'h00);
    acks = 0;
    host.send_cmd(c[15:8], c[7:0], am);
    host.hold(1'b1, 300);
    check(11'(code), 11'(ec));
    check(mv, em);
    check(11'(acks), 11'(ea));
    check(11'({drv, oe_n}), 11'h001);
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (!oe_n)
      acks++;
    if (cycles == 90000)
    begin
      failures++;
      results();
    end
  end
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (5) @(negedge clock_i);
    check(11'(code), 11'h01F);
    check(mv, 11'h4CD);
    rst_n_i = 1'b1;
    host.hold(1'b1, DET_DELAY_CYC + 100);
    check(11'(sw_en), 11'h001);
    host.hold(1'b0, LOW_C + 20);
    check(11'(ser), 11'h001);
    cmd(16'h728D, 5'h0D, 11'h10E, ACK_C);
    cmd(16'h7218, 5'h18, 11'h2C9, 0);
    cmd(16'h7380, 5'h18, 11'h2C9, 0);
    cmd(16'h72C1, 5'h18, 11'h2C9, 0);
    cmd(16'h728F, 5'h18, 11'h2C9, 0, 8'h01);
    cmd(16'h7280, 5'h00, 11'h000, ACK_C);
    hold_lvl = 1'b1;
    cmd(16'h729F, 5'h00, 11'h000, ACK_C);
    cmd(16'h7281, 5'h00, 11'h000, ACK_C);
    cmd(16'h7282, 5'h00, 11'h000, 0);
    hold_lvl = 1'b0;
    repeat (10) @(negedge clock_i);
    check(11'({ser, code}), 11'h021);
    check(mv, 11'h01F);
    host.hold(1'b0, SD_C - 50);
    check(11'(sw_en), 11'h001);
    host.hold(1'b0, 70);
    check(11'(sw_en), 11'h000);
    host.hold(1'b1, WIN_C + 100);
    check(11'({ser, gate}), 11'h001);
    check(mv, 11'h4CD);
    for (int i = 0; i < 3; i++)
    begin
      host.hold(1'b0, 300);
      check(11'(gate), 11'h000);
      host.hold(1'b1, 100);
      check(11'(gate), 11'h001);
    end
    check(11'({ser, sw_en}), 11'h001);
    for (int f = 0; f < 2; f++)
    begin
      {hot, lockout} = f ? 2'b10 : 2'b01;
      repeat (10) @(negedge clock_i);
      check(11'({sw_en, gate}), 11'h000);
      {hot, lockout} = 2'b00;
      repeat (10) @(negedge clock_i);
      check(11'(sw_en), 11'h001);
    end
    results();
  end
endmodule // test_oref_ctrl
`default_nettype wire
